/* core/gwm_warning_monitor.sv */
`timescale 1ns/1ps
module gwm_warning_monitor #(
    parameter int TICK_CYCLES = gwm_pkg::TICK_CYCLES
) (
    input  wire logic                                MCLK_IN,
    input  wire logic                                RESET_N_IN,
    input  wire logic                                ENGINE_RUN_IN,
    input  wire logic                                STOP_CMD_IN,
    input  wire logic                                LATCH_ALL_IN,
    input  wire logic                                ACK_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           HOLDOFF_MS_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          GEN_FREQ_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          FREQ_LO_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          FREQ_HI_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           FREQ_DLY_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          GEN_RPM_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          RPM_LO_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          RPM_HI_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          RPM_OVERSHOOT_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           RPM_DLY_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          VOLT_L1_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          VOLT_L2_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          VOLT_L3_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          VOLT_LO_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          VOLT_HI_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           VOLT_FAIL_MS_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          BATT_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          BATT_LO_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          BATT_HI_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           BATT_DLY_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           STOP_TMR_MS_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          CHARGE_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          CHARGE_LO_IN,
    input  wire logic                                ENGINE_FAULT_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          UNBAL_LIM_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          CURR_L1_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          CURR_L2_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          CURR_L3_IN,
    input  wire logic [gwm_pkg::ACT_W-1:0]           CURR_UNBAL_ACT_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          OC_LIM_IN,
    input  wire logic [gwm_pkg::ACC_W-1:0]           IDMT_K_IN,
    input  wire logic [gwm_pkg::ACT_W-1:0]           IDMT_ACT_IN,
    input  wire logic signed [gwm_pkg::MEAS_W-1:0]   POWER_IN,
    input  wire logic [gwm_pkg::MEAS_W-1:0]          RPOW_LIM_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           RPOW_MS_IN,
    input  wire logic                                MORD_EN_IN,
    input  wire logic                                MAINS_PRESENT_IN,
    input  wire logic                                MAINS_REVERSED_IN,
    input  wire logic                                CB_FB_DEF_IN,
    input  wire logic                                CB_CMD_IN,
    input  wire logic                                CB_FB_IN,
    input  wire logic [gwm_pkg::TMR_W-1:0]           CB_FAIL_MS_IN,
    input  wire logic [gwm_pkg::NDI-1:0]             DIG_IN_IN,
    input  wire logic [gwm_pkg::NDI-1:0]             DIG_POL_IN,
    input  wire logic [gwm_pkg::NDI-1:0]             DIG_HOLD_IN,
    input  wire logic [gwm_pkg::NDI*gwm_pkg::ACT_W-1:0] DIG_ACT_IN,
    output logic      [gwm_pkg::NW-1:0]              WARN_OUT,
    output logic      [gwm_pkg::NDI-1:0]             DIG_WARN_OUT,
    output logic                                     STOP_REQ_OUT,
    output logic                                     MAINS_INHIBIT_OUT
);
    import gwm_pkg::*;

    typedef struct packed {
        logic [NSYNC-1:0]            s1;
        logic [NSYNC-1:0]            s2;
        logic [TMR_W-1:0]            tick_cnt;
        logic                        tick;
        logic [TMR_W-1:0]            hold_cnt;
        logic                        hold_done;
        logic [NQ-1:0][TMR_W-1:0]    qcnt;
        logic [TMR_W-1:0]            stop_cnt;
        logic [ACC_W-1:0]            idmt_acc;
        logic [NW-1:0]               warn;
        logic [NDI-1:0]              dig_warn;
        logic                        stop;
        logic                        inhibit;
    } gwm_state_type;

    localparam logic [TMR_W-1:0] TICK_LAST = TMR_W'(TICK_CYCLES - 1);

    logic [1:0]               rst_pipe;
    logic                     rst_n;
    gwm_state_type            st;
    gwm_state_type            nx;
    logic                     run;
    logic                     fb;
    logic [NQ-1:0]            qraw;
    logic [NQ-1:0][TMR_W-1:0] qdly;
    logic [MEAS_W-1:0]        imax;
    logic                     freq_sd;
    logic                     rpm_os;
    logic                     oc_raw;
    logic                     mord_raw;
    logic                     fts_raw;
    logic                     chg_raw;
    logic                     batt_raw;

    // three phase deviation from average, scaled by three to avoid a divider
    function automatic logic unbal(input logic [MEAS_W-1:0] a, input logic [MEAS_W-1:0] b,
                                   input logic [MEAS_W-1:0] c, input logic [MEAS_W-1:0] lim);
        logic [MEAS_W+1:0] sum;
        logic [MEAS_W+1:0] lim3;
        logic [MEAS_W+1:0] x3;
        logic              hit;
        sum  = {2'h0, a} + {2'h0, b} + {2'h0, c};
        lim3 = (MEAS_W+2)'(UNB_PHASES) * {2'h0, lim};
        hit  = 1'b0;
        for (int k = 0; k < UNB_PHASES; k++) begin
            x3 = (MEAS_W+2)'(UNB_PHASES) * {2'h0, (k == 0) ? a : ((k == 1) ? b : c)};
            if (x3 > sum) begin
                hit = hit | ((x3 - sum) > lim3);
            end else begin
                hit = hit | ((sum - x3) > lim3);
            end
        end
        return hit;
    endfunction : unbal

    // reset release through two flip-flops
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // synchronised pin levels
    assign run = st.s2[S_RUN];
    assign fb  = st.s2[S_FB];

    // largest phase current
    assign imax = (CURR_L1_IN >= CURR_L2_IN && CURR_L1_IN >= CURR_L3_IN) ? CURR_L1_IN :
                  ((CURR_L2_IN >= CURR_L3_IN) ? CURR_L2_IN : CURR_L3_IN);

    assign freq_sd = ({16'h0, GEN_FREQ_IN} * 32'(PCT_FULL)) >
                     ({16'h0, FREQ_HI_IN} * 32'(PCT_FULL + FREQ_SD_PCT));
    assign rpm_os  = GEN_RPM_IN > RPM_OVERSHOOT_IN;
    assign oc_raw  = imax > OC_LIM_IN;
    assign mord_raw = MORD_EN_IN && MAINS_PRESENT_IN && MAINS_REVERSED_IN;
    assign fts_raw = STOP_CMD_IN && run && (st.stop_cnt >= STOP_TMR_MS_IN);
    assign chg_raw = st.hold_done && (CHARGE_IN < CHARGE_LO_IN);
    assign batt_raw = (BATT_IN < BATT_LO_IN) || (BATT_IN > BATT_HI_IN);

    // raw conditions feeding the delay qualifiers
    always_comb begin
        qraw[Q_FREQ] = st.hold_done && (GEN_FREQ_IN < FREQ_LO_IN || GEN_FREQ_IN > FREQ_HI_IN);
        qraw[Q_RPM]  = st.hold_done && (GEN_RPM_IN < RPM_LO_IN || GEN_RPM_IN > RPM_HI_IN);
        // any phase voltage out of window
        qraw[Q_VOLT] = st.hold_done && (VOLT_L1_IN < VOLT_LO_IN || VOLT_L1_IN > VOLT_HI_IN ||
                                        VOLT_L2_IN < VOLT_LO_IN || VOLT_L2_IN > VOLT_HI_IN ||
                                        VOLT_L3_IN < VOLT_LO_IN || VOLT_L3_IN > VOLT_HI_IN);
        qraw[Q_BATT] = batt_raw;
        qraw[Q_VUNB] = st.hold_done && unbal(VOLT_L1_IN, VOLT_L2_IN, VOLT_L3_IN, UNBAL_LIM_IN);
        qraw[Q_IUNB] = st.hold_done && unbal(CURR_L1_IN, CURR_L2_IN, CURR_L3_IN, UNBAL_LIM_IN);
        qraw[Q_RPOW] = POWER_IN[MEAS_W-1] && (MEAS_W'(-POWER_IN) > RPOW_LIM_IN);
        qraw[Q_CB]   = CB_FB_DEF_IN && (fb != CB_CMD_IN);
    end

    // detection delays per qualifier, in milliseconds
    assign qdly[Q_FREQ] = FREQ_DLY_IN;
    assign qdly[Q_RPM]  = RPM_DLY_IN;
    assign qdly[Q_VOLT] = VOLT_FAIL_MS_IN;
    assign qdly[Q_BATT] = BATT_DLY_IN;
    assign qdly[Q_VUNB] = VOLT_FAIL_MS_IN;
    assign qdly[Q_IUNB] = VOLT_FAIL_MS_IN;
    assign qdly[Q_RPOW] = RPOW_MS_IN;
    assign qdly[Q_CB]   = CB_FAIL_MS_IN;

    // next state of the whole monitor
    always_comb begin
        logic [NQ-1:0]     qok;
        logic [NW-1:0]     w;
        logic [NDI-1:0]    dw;
        logic [MEAS_W-1:0] excess;
        logic [ACC_W:0]    acc_sum;
        logic              trip;
        logic              dig_stop;
        logic              cause;
        logic [ACT_W-1:0]  act;
        qok      = '0;
        w        = '0;
        dw       = '0;
        excess   = '0;
        acc_sum  = '0;
        trip     = 1'b0;
        dig_stop = 1'b0;
        cause    = 1'b0;
        act      = ACT_NONE;
        nx       = st;
        nx.s1    = {DIG_IN_IN, CB_FB_IN, ENGINE_RUN_IN};
        nx.s2    = st.s1;
        // millisecond tick divider
        nx.tick  = 1'b0;
        if (st.tick_cnt >= TICK_LAST) begin
            nx.tick_cnt = '0;
            nx.tick     = 1'b1;
        end else begin
            nx.tick_cnt = st.tick_cnt + 16'h1;
        end
        // holdoff after the engine starts running
        if (!run) begin
            nx.hold_cnt = '0;
        end else if (st.tick && st.hold_cnt < HOLDOFF_MS_IN) begin
            nx.hold_cnt = st.hold_cnt + 16'h1;
        end
        nx.hold_done = run && (st.hold_cnt >= HOLDOFF_MS_IN);
        // delay qualifiers restart whenever their condition drops
        for (int i = 0; i < NQ; i++) begin
            if (!qraw[i]) begin
                nx.qcnt[i] = '0;
            end else if (st.tick && st.qcnt[i] < qdly[i]) begin
                nx.qcnt[i] = st.qcnt[i] + 16'h1;
            end
            qok[i] = qraw[i] && (st.qcnt[i] >= qdly[i]);
        end
        // stop timer runs while stop is commanded
        if (!STOP_CMD_IN) begin
            nx.stop_cnt = '0;
        end else if (st.tick && st.stop_cnt < STOP_TMR_MS_IN) begin
            nx.stop_cnt = st.stop_cnt + 16'h1;
        end
        // inverse time: excess integrated per tick against the curve constant
        if (!oc_raw) begin
            nx.idmt_acc = '0;
        end else begin
            excess  = imax - OC_LIM_IN;
            acc_sum = {1'b0, st.idmt_acc} + {17'h0, excess};
            if (st.tick) begin
                nx.idmt_acc = acc_sum[ACC_W] ? {ACC_W{1'b1}} : acc_sum[ACC_W-1:0];
            end
        end
        trip = oc_raw && (st.idmt_acc >= IDMT_K_IN);
        // warning sources
        w[W_FREQ]     = qok[Q_FREQ];
        w[W_RPM]      = qok[Q_RPM];
        w[W_VOLT]     = qok[Q_VOLT];
        w[W_BATT]     = qok[Q_BATT];
        w[W_FTS]      = fts_raw;
        w[W_CHG]      = chg_raw;
        w[W_ECU]      = ENGINE_FAULT_IN;
        w[W_VUNB]     = qok[Q_VUNB];
        w[W_IUNB]     = qok[Q_IUNB] && (CURR_UNBAL_ACT_IN != ACT_NONE);
        w[W_IDMT]     = trip && (IDMT_ACT_IN != ACT_NONE);
        w[W_OC]       = oc_raw;
        w[W_RPOW]     = qok[Q_RPOW];
        w[W_MORD]     = mord_raw;
        w[W_CB_CLOSE] = qok[Q_CB] && CB_CMD_IN;
        w[W_CB_OPEN]  = qok[Q_CB] && !CB_CMD_IN;
        // digital inputs with polarity, sampling window and action
        for (int d = 0; d < NDI; d++) begin
            act   = DIG_ACT_IN[d*ACT_W +: ACT_W];
            dw[d] = ((st.s2[S_DIG+d] ^ DIG_POL_IN[d]) && (!DIG_HOLD_IN[d] || st.hold_done) &&
                     act != ACT_NONE);
            dig_stop = dig_stop | (dw[d] && act == ACT_STOP);
        end
        // global latch; held until acknowledge, new event wins
        nx.warn     = w | (st.warn & {NW{LATCH_ALL_IN && !ACK_IN}});
        nx.dig_warn = dw | (st.dig_warn & {NDI{LATCH_ALL_IN && !ACK_IN}});
        cause   = freq_sd || rpm_os || dig_stop ||
                  (qok[Q_IUNB] && CURR_UNBAL_ACT_IN == ACT_STOP) ||
                  (trip && IDMT_ACT_IN == ACT_STOP);
        nx.stop = cause || (st.stop && !ACK_IN);
        // closing inhibited while order is reversed
        nx.inhibit = mord_raw;
    end

    // state register
    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from the state register
    assign WARN_OUT          = st.warn;
    assign DIG_WARN_OUT      = st.dig_warn;
    assign STOP_REQ_OUT      = st.stop;
    assign MAINS_INHIBIT_OUT = st.inhibit;

    default clocking cb_main @(posedge MCLK_IN); endclocking
    default disable iff (!rst_n);

    property p_freq_sd;
        freq_sd |=> st.stop;
    endproperty
    a_freq_sd: assert property (p_freq_sd) else $error("frequency shutdown missed");

    property p_rpm_os;
        rpm_os |=> st.stop ##0 STOP_REQ_OUT;
    endproperty
    a_rpm_os: assert property (p_rpm_os) else $error("rpm overshoot stop missed");

    property p_freq_holdoff;
        (!st.hold_done && !LATCH_ALL_IN) |=> !st.warn[W_FREQ];
    endproperty
    a_freq_holdoff: assert property (p_freq_holdoff) else $error("frequency warned in holdoff");

    property p_rpm_delay;
        (qraw[Q_RPM] && st.qcnt[Q_RPM] < RPM_DLY_IN && !LATCH_ALL_IN && !st.warn[W_RPM])
            |=> !st.warn[W_RPM];
    endproperty
    a_rpm_delay: assert property (p_rpm_delay) else $error("rpm warned before delay");

    property p_oc;
        oc_raw |=> st.warn[W_OC];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent flag missing");

    property p_latch;
        (LATCH_ALL_IN && !ACK_IN && st.warn[W_BATT]) |=> st.warn[W_BATT];
    endproperty
    a_latch: assert property (p_latch) else $error("latched battery warning lost");

    property p_nolatch;
        (!LATCH_ALL_IN && !batt_raw) |=> !st.warn[W_BATT];
    endproperty
    a_nolatch: assert property (p_nolatch) else $error("battery warning stuck");

    property p_mord;
        mord_raw |=> (MAINS_INHIBIT_OUT && st.warn[W_MORD]);
    endproperty
    a_mord: assert property (p_mord) else $error("mains order not flagged");

    property p_ecu;
        ENGINE_FAULT_IN |=> st.warn[W_ECU];
    endproperty
    a_ecu: assert property (p_ecu) else $error("engine unit fault not flagged");

    property p_cb;
        (!LATCH_ALL_IN && !qraw[Q_CB]) |=> !(st.warn[W_CB_CLOSE] || st.warn[W_CB_OPEN]);
    endproperty
    a_cb: assert property (p_cb) else $error("breaker failure without cause");

    property p_fts;
        (!LATCH_ALL_IN && !STOP_CMD_IN) |=> !st.warn[W_FTS];
    endproperty
    a_fts: assert property (p_fts) else $error("fail to stop without stop command");

    c_freq_warn: cover property (st.hold_done ##1 st.warn[W_FREQ]);
    c_idmt_trip: cover property (oc_raw ##1 st.warn[W_IDMT]);
    c_latch_ack: cover property (LATCH_ALL_IN && st.warn[W_BATT] && ACK_IN ##1 !st.warn[W_BATT]);
    c_cb_fail:   cover property (st.warn[W_CB_CLOSE]);

endmodule : gwm_warning_monitor

/* core/gwm_pkg.sv */
package gwm_pkg;
    localparam int MEAS_W         = 16;
    localparam int TMR_W          = 16;
    localparam int ACC_W          = 32;
    localparam int ACT_W          = 2;
    localparam int NDI            = 4;
    // clock and millisecond tick
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // shutdown threshold above the high frequency limit, in percent
    localparam int FREQ_SD_PCT    = 12;
    localparam int PCT_FULL       = 100;
    localparam int UNB_PHASES     = 3;
    // actions
    localparam logic [ACT_W-1:0] ACT_NONE = 2'h0;
    localparam logic [ACT_W-1:0] ACT_WARN = 2'h1;
    localparam logic [ACT_W-1:0] ACT_STOP = 2'h2;
    // qualifier timer slots
    localparam int NQ     = 8;
    localparam int Q_FREQ = 0;
    localparam int Q_RPM  = 1;
    localparam int Q_VOLT = 2;
    localparam int Q_BATT = 3;
    localparam int Q_VUNB = 4;
    localparam int Q_IUNB = 5;
    localparam int Q_RPOW = 6;
    localparam int Q_CB   = 7;
    // warning vector bits
    localparam int NW         = 15;
    localparam int W_FREQ     = 0;
    localparam int W_RPM      = 1;
    localparam int W_VOLT     = 2;
    localparam int W_BATT     = 3;
    localparam int W_FTS      = 4;
    localparam int W_CHG      = 5;
    localparam int W_ECU      = 6;
    localparam int W_VUNB     = 7;
    localparam int W_IUNB     = 8;
    localparam int W_IDMT     = 9;
    localparam int W_OC       = 10;
    localparam int W_RPOW     = 11;
    localparam int W_MORD     = 12;
    localparam int W_CB_CLOSE = 13;
    localparam int W_CB_OPEN  = 14;
    // synchroniser slots
    localparam int NSYNC = 2 + NDI;
    localparam int S_RUN = 0;
    localparam int S_FB  = 1;
    localparam int S_DIG = 2;
endpackage : gwm_pkg

/* dv/gwm_partner.sv */
`timescale 1ns/1ps
// far side: engine run pin and contactor feedback contact
module gwm_partner (
    input  wire logic       clk_in,
    input  wire logic       run_req_in,
    input  wire logic       cb_cmd_in,
    input  wire logic [1:0] mode_in,
    output logic            run_out,
    output logic            cb_fb_out
);
    logic [3:0] lag;
    // feedback follows the command: mode 0 prompt, 1 after 8 cycles, 2 never
    always @(posedge clk_in) begin
        run_out <= run_req_in;
        lag     <= (cb_fb_out == cb_cmd_in) ? 4'h0 : lag + 4'h1;
        if (mode_in == 2'h2)
            cb_fb_out <= 1'h0;
        else if (mode_in == 2'h0 || lag == 4'h8)
            cb_fb_out <= cb_cmd_in;
    end
    initial begin
        run_out   = 1'h0;
        cb_fb_out = 1'h0;
        lag       = 4'h0;
    end
endmodule : gwm_partner

/* dv/gwm_warning_monitor_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module gwm_warning_monitor_bench;
    import gwm_pkg::*;
    logic              mclk, rst_n, run_req, stop_cmd, latch_all, ack, fault, mord_en, pres, rev;
    logic              fb_def, cb_cmd, run_pin, cb_fb;
    logic [1:0]        fb_mode;
    logic [MEAS_W-1:0] freq, f_lo, f_hi, rpm, r_lo, r_hi, r_os, v1, v_lo, v_hi, batt, b_lo, b_hi;
    logic [MEAS_W-1:0] chg, chg_lo, unb, i1, i23, oc, rp_lim;
    logic [NDI-1:0]    dig, dig_warn;
    logic [TMR_W-1:0]  holdoff, dly, cb_ms, rp_ms, b_dly;
    logic [ACC_W-1:0]  idmt_k;
    logic signed [MEAS_W-1:0] pwr;
    logic [NW-1:0]     warn;
    logic              stop_req, inhibit;
    int                num_errors, comparisons, cycles;

    always #10 mclk = ~mclk;

    gwm_partner peer (.clk_in(mclk), .run_req_in(run_req), .cb_cmd_in(cb_cmd), .mode_in(fb_mode),
        .run_out(run_pin), .cb_fb_out(cb_fb));

    gwm_warning_monitor #(.TICK_CYCLES(4)) dut (
        .MCLK_IN(mclk), .RESET_N_IN(rst_n), .ENGINE_RUN_IN(run_pin), .STOP_CMD_IN(stop_cmd),
        .LATCH_ALL_IN(latch_all), .ACK_IN(ack), .HOLDOFF_MS_IN(holdoff), .GEN_FREQ_IN(freq),
        .FREQ_LO_IN(f_lo), .FREQ_HI_IN(f_hi), .FREQ_DLY_IN(dly), .GEN_RPM_IN(rpm), .RPM_LO_IN(r_lo),
        .RPM_HI_IN(r_hi), .RPM_OVERSHOOT_IN(r_os), .RPM_DLY_IN(dly), .VOLT_L1_IN(v1), .VOLT_L2_IN(v1),
        .VOLT_L3_IN(v1), .VOLT_LO_IN(v_lo), .VOLT_HI_IN(v_hi), .VOLT_FAIL_MS_IN(dly), .BATT_IN(batt),
        .BATT_LO_IN(b_lo), .BATT_HI_IN(b_hi), .BATT_DLY_IN(b_dly), .STOP_TMR_MS_IN(dly),
        .CHARGE_IN(chg), .CHARGE_LO_IN(chg_lo), .ENGINE_FAULT_IN(fault), .UNBAL_LIM_IN(unb),
        .CURR_L1_IN(i1), .CURR_L2_IN(i23), .CURR_L3_IN(i23), .CURR_UNBAL_ACT_IN(ACT_WARN),
        .OC_LIM_IN(oc), .IDMT_K_IN(idmt_k), .IDMT_ACT_IN(ACT_STOP), .POWER_IN(pwr),
        .RPOW_LIM_IN(rp_lim), .RPOW_MS_IN(rp_ms), .MORD_EN_IN(mord_en), .MAINS_PRESENT_IN(pres),
        .MAINS_REVERSED_IN(rev), .CB_FB_DEF_IN(fb_def), .CB_CMD_IN(cb_cmd), .CB_FB_IN(cb_fb),
        .CB_FAIL_MS_IN(cb_ms), .DIG_IN_IN(dig), .DIG_POL_IN(4'h0), .DIG_HOLD_IN(4'h0),
        .DIG_ACT_IN(8'h55), .WARN_OUT(warn), .DIG_WARN_OUT(dig_warn), .STOP_REQ_OUT(stop_req),
        .MAINS_INHIBIT_OUT(inhibit));

    // let n edges pass, then sample settled outputs
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    // prints the counts and the verdict, then stops
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        mclk = 0; rst_n = 0; run_req = 0; stop_cmd = 0; latch_all = 0; ack = 0; fault = 0;
        mord_en = 0; pres = 0; rev = 0; fb_def = 1; cb_cmd = 0; fb_mode = 2'h1;
        freq = 16'h01F4; f_lo = 16'h01C2; f_hi = 16'h0226; rpm = 16'h05DC; r_lo = 16'h0578;
        r_hi = 16'h0640; r_os = 16'h06A4; v1 = 16'h00E6; v_lo = 16'h00C8; v_hi = 16'h0104;
        batt = 16'h0078; b_lo = 16'h0064; b_hi = 16'h0096; chg = 16'h0078; chg_lo = 16'h0032;
        unb = 16'h0100; i1 = 16'h0064; oc = 16'h00C8; idmt_k = 32'h0000_0010; pwr = 16'sh0000;
        rp_lim = 16'h0064; holdoff = 16'h0002; dly = 16'h0002; cb_ms = 16'h0003; rp_ms = 16'h0003;
        b_dly = 16'h0003; num_errors = 0; comparisons = 0; cycles = 0; i23 = 16'h0064; dig = 4'h0;
        wt(20); @(posedge mclk); rst_n <= 1; wt(3);
        // inverse time: excess 4 per ms against K 16 needs four ticks
        @(posedge mclk); i1 <= 16'h00CC; wt(2);
        `CHK(warn[W_OC], 1'h1)
        wt(6); `CHK(warn[W_IDMT], 1'h0)
        wt(22); `CHK(warn[W_IDMT], 1'h1)
        `CHK(stop_req, 1'h1)
        @(posedge mclk); i1 <= 16'h0064; wt(2); @(posedge mclk); ack <= 1; @(posedge mclk); ack <= 0; wt(2);
        `CHK(stop_req, 1'h0)
        // latch all: short blip stays until acknowledge
        @(posedge mclk); latch_all <= 1; i1 <= 16'h00C9; wt(2); @(posedge mclk); i1 <= 16'h0064; wt(4);
        `CHK(warn[W_OC], 1'h1)
        @(posedge mclk); ack <= 1; @(posedge mclk); ack <= 0; latch_all <= 0; wt(2);
        `CHK(warn[W_OC], 1'h0)
        done("overcurrent");
        // shutdown at exactly 12 percent over is not exceeded, one more is
        @(posedge mclk); freq <= 16'h0268; wt(4); `CHK(stop_req, 1'h0)
        @(posedge mclk); freq <= 16'h0269; wt(2); `CHK(stop_req, 1'h1)
        @(posedge mclk); freq <= 16'h01F4; ack <= 1; @(posedge mclk); ack <= 0; wt(2);
        @(posedge mclk); rpm <= 16'h06A5; wt(2); `CHK(stop_req, 1'h1)
        @(posedge mclk); rpm <= 16'h05DC; ack <= 1; @(posedge mclk); ack <= 0; fault <= 1; wt(2);
        `CHK(warn[W_ECU], 1'h1)
        `CHK(stop_req, 1'h0)
        @(posedge mclk); fault <= 0; mord_en <= 1; pres <= 1; rev <= 1; wt(2);
        `CHK({warn[W_MORD], inhibit}, 2'h3)
        @(posedge mclk); pres <= 0; wt(2); `CHK({warn[W_MORD], inhibit}, 2'h0)
        done("immediate");
        // battery needs three ms, reverse power blip cancels
        @(posedge mclk); batt <= 16'h0063; wt(8); `CHK(warn[W_BATT], 1'h0)
        wt(12); `CHK(warn[W_BATT], 1'h1)
        @(posedge mclk); batt <= 16'h0078; pwr <= -16'sh0065; wt(6); @(posedge mclk); pwr <= 16'sh0000;
        wt(20); `CHK(warn[W_RPOW], 1'h0)
        @(posedge mclk); pwr <= -16'sh0065; wt(24); `CHK(warn[W_RPOW], 1'h1)
        @(posedge mclk); pwr <= 16'sh0000; done("timed");
        // holdoff gates frequency and charge until the engine runs
        @(posedge mclk); freq <= 16'h0190; chg <= 16'h000A; wt(40);
        `CHK({warn[W_FREQ], warn[W_CHG]}, 2'h0)
        @(posedge mclk); run_req <= 1; wt(60);
        `CHK({warn[W_FREQ], warn[W_CHG]}, 2'h3)
        @(posedge mclk); stop_cmd <= 1; wt(30); `CHK(warn[W_FTS], 1'h1)
        @(posedge mclk); freq <= 16'h01F4; chg <= 16'h0078; stop_cmd <= 0; run_req <= 0; wt(6);
        `CHK(warn[W_FREQ], 1'h0)
        done("holdoff");
        // slow feedback just past the fail time, the warning blips and clears before the check, then none at all
        @(posedge mclk); cb_cmd <= 1; wt(30); `CHK(warn[W_CB_CLOSE], 1'h0)
        @(posedge mclk); cb_cmd <= 0; wt(30); `CHK(warn[W_CB_OPEN], 1'h0)
        @(posedge mclk); fb_mode <= 2'h2; cb_cmd <= 1; wt(30); `CHK(warn[W_CB_CLOSE], 1'h1)
        done("contactor");
        // digital input with warn action follows its synchronised pin
        @(posedge mclk); dig <= 4'h1; wt(4); `CHK(dig_warn, 4'h1)
        @(posedge mclk); dig <= 4'h0; wt(4); `CHK(dig_warn, 4'h0)
        `CHK(stop_req, 1'h0)
        done("digital");
        final_report();
    end
endmodule : gwm_warning_monitor_bench
